// ==== src/dfeh_top.v ====
`include "dfeh_consts.vh"
`timescale 1ns/100ps
`default_nettype none
module dfeh_top #(
   parameter HDR_W = 32
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   input wire tlp_valid,
   input wire tlp_ecrc_bad,
   input wire [HDR_W-1:0] tlp_header,
   output reg tlp_fwd_valid,
   output reg [HDR_W-1:0] tlp_fwd_header,
   input wire sec_active,
   input wire [1:0] sec_kind,
   input wire sec_poisoned,
   input wire [HDR_W-1:0] sec_cmd_attr_addr,
   input wire parity_error_pin_in,
   output reg parity_error_pin_out,
   output reg parity_error_pin_oe,
   input wire sec_read_data_err,
   input wire sec_split_resp,
   input wire sec_split_err_msg,
   input wire sec_end,
   output wire sec_continue,
   output reg cpl_valid,
   output reg [2:0] cpl_status,
   output reg cpl_poisoned,
   output reg msg_fatal,
   output reg msg_nonfatal
);
   // Transaction kinds on the secondary bus
   localparam [1:0] KIND_PW = 2'h0;
   localparam [1:0] KIND_NPW = 2'h1;
   localparam [1:0] KIND_RD = 2'h2;
   localparam [1:0] KIND_SPLC = 2'h3;

   // ******************************
   // Input synchronisers
   // ******************************
   reg perr_m_r, perr_s_r;
   // Pin is asynchronous to pclk; second flop is the only reader of the first
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         perr_m_r <= 1'b1;
         perr_s_r <= 1'b1;
      end else begin
         perr_m_r <= parity_error_pin_in;
         perr_s_r <= perr_m_r;
      end
   end
   wire perr_seen = ~perr_s_r;

   // ******************************
   // Registers
   // ******************************
   reg [3:0] ctrl_r;
   reg [4:0] stat_r;
   reg unc_stat_r, unc_mask_r, unc_sev_r;
   reg [HDR_W-1:0] hdr_log_r;
   reg [1:0] sec_stat_r, sec_unc_r, sec_mask_r, sec_sev_r;
   reg [HDR_W-1:0] sec_hdr_r;
   reg [8:0] sec_fep_r;
   reg rd_err_r;

   wire serr_en = ctrl_r[`DFEH_CTRL_SERR_EN];
   wire perr_rsp = ctrl_r[`DFEH_CTRL_SEC_PERR_RSP];
   wire wr_acc = psel & penable & pwrite;
   wire [31:0] w1c = wr_acc ? pwdata : 32'h00000000;

   // ******************************
   // Error events
   // ******************************
   wire ecrc_ev = tlp_valid & tlp_ecrc_bad;
   // Parity pin on a non-poisoned forwarded write or split completion
   wire perr_ev = sec_active & ~sec_poisoned & perr_seen & (sec_kind != KIND_RD);
   wire ude_ev = sec_active & sec_read_data_err & (sec_kind == KIND_RD);
   wire ecrc_unm = ecrc_ev & ~unc_mask_r;
   wire perr_unm = perr_ev & ~sec_mask_r[`DFEH_SEC_PERR_DET];
   wire ude_unm = ude_ev & ~sec_mask_r[`DFEH_SEC_UDE];
   wire fat_req = (ecrc_ev & unc_sev_r) | (perr_ev & sec_sev_r[0]) | (ude_ev & sec_sev_r[1]);
   wire nf_req = (ecrc_ev & ~unc_sev_r) | (perr_ev & ~sec_sev_r[0]) | (ude_ev & ~sec_sev_r[1]);
   wire fat_unm = (ecrc_unm & unc_sev_r) | (perr_unm & sec_sev_r[0]) | (ude_unm & sec_sev_r[1]);
   wire nf_unm = (ecrc_unm & ~unc_sev_r) | (perr_unm & ~sec_sev_r[0]) | (ude_unm & ~sec_sev_r[1]);
   wire fat_en = serr_en | ctrl_r[`DFEH_CTRL_FAT_EN];
   wire nf_en = serr_en | ctrl_r[`DFEH_CTRL_NF_EN];

   // Transfer never stops on an error; it ends only with the target
   assign sec_continue = sec_active;

   // ******************************
   // APB slave, zero wait states
   // ******************************
   assign pready = 1'b1;
   reg addr_ok;
   always @* begin
      addr_ok = 1'b1;
      prdata = 32'h00000000;
      case (paddr)
         `DFEH_OFF_CTRL: prdata = {28'h0000000, ctrl_r};
         `DFEH_OFF_STAT: prdata = {27'h0000000, stat_r};
         `DFEH_OFF_UNC_STAT: prdata = {31'h00000000, unc_stat_r};
         `DFEH_OFF_UNC_MASK: prdata = {31'h00000000, unc_mask_r};
         `DFEH_OFF_UNC_SEV: prdata = {31'h00000000, unc_sev_r};
         `DFEH_OFF_HDR_LOG: prdata = hdr_log_r;
         `DFEH_OFF_SEC_STAT: prdata = {30'h00000000, sec_stat_r};
         `DFEH_OFF_SEC_UNC_STAT: prdata = {30'h00000000, sec_unc_r};
         `DFEH_OFF_SEC_MASK: prdata = {30'h00000000, sec_mask_r};
         `DFEH_OFF_SEC_SEV: prdata = {30'h00000000, sec_sev_r};
         `DFEH_OFF_SEC_HDR_LOG: prdata = sec_hdr_r;
         `DFEH_OFF_SEC_FEP: prdata = {23'h000000, sec_fep_r};
         default: addr_ok = 1'b0;
      endcase
   end
   assign pslverr = psel & penable & ~addr_ok;

   // Configuration registers
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r <= 4'h0;
         unc_mask_r <= 1'b0;
         unc_sev_r <= 1'b0;
         sec_mask_r <= 2'h0;
         sec_sev_r <= 2'h0;
      end else if (wr_acc) begin
         case (paddr)
            `DFEH_OFF_CTRL: ctrl_r <= pwdata[3:0];
            `DFEH_OFF_UNC_MASK: unc_mask_r <= pwdata[0];
            `DFEH_OFF_UNC_SEV: unc_sev_r <= pwdata[0];
            `DFEH_OFF_SEC_MASK: sec_mask_r <= pwdata[1:0];
            `DFEH_OFF_SEC_SEV: sec_sev_r <= pwdata[1:0];
            default: ctrl_r <= ctrl_r;
         endcase
      end
   end

   // ******************************
   // Sticky status; a new event wins over a clear in the same cycle, except at a first error pointer already valid, where the clear wins
   // ******************************
   wire sel_stat = paddr == `DFEH_OFF_STAT;
   wire sel_unc = paddr == `DFEH_OFF_UNC_STAT;
   wire sel_sst = paddr == `DFEH_OFF_SEC_STAT;
   wire sel_sun = paddr == `DFEH_OFF_SEC_UNC_STAT;
   wire sel_fep = paddr == `DFEH_OFF_SEC_FEP;
   wire sig_serr = serr_en & (ecrc_unm | perr_unm | ude_unm);
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stat_r <= 5'h00;
         unc_stat_r <= 1'b0;
         sec_stat_r <= 2'h0;
         sec_unc_r <= 2'h0;
         hdr_log_r <= {HDR_W{1'b0}};
         sec_hdr_r <= {HDR_W{1'b0}};
         sec_fep_r <= 9'h000;
      end else begin
         stat_r[`DFEH_STAT_DET_PERR] <= ecrc_ev |
            (stat_r[`DFEH_STAT_DET_PERR] & ~(sel_stat & w1c[`DFEH_STAT_DET_PERR]));
         stat_r[`DFEH_STAT_SIG_SERR] <= sig_serr |
            (stat_r[`DFEH_STAT_SIG_SERR] & ~(sel_stat & w1c[`DFEH_STAT_SIG_SERR]));
         // Detected bits ignore the reporting enables
         stat_r[`DFEH_STAT_NF_DET] <= nf_req |
            (stat_r[`DFEH_STAT_NF_DET] & ~(sel_stat & w1c[`DFEH_STAT_NF_DET]));
         stat_r[`DFEH_STAT_FAT_DET] <= fat_req |
            (stat_r[`DFEH_STAT_FAT_DET] & ~(sel_stat & w1c[`DFEH_STAT_FAT_DET]));
         unc_stat_r <= ecrc_ev | (unc_stat_r & ~(sel_unc & w1c[`DFEH_UNC_ECRC]));
         // Primary first error pointer, held until software clears it
         if (ecrc_unm & ~stat_r[`DFEH_STAT_FEP_VALID]) begin
            stat_r[`DFEH_STAT_FEP_VALID] <= 1'b1;
            hdr_log_r <= tlp_header;
         end else if (sel_stat & w1c[`DFEH_STAT_FEP_VALID]) begin
            stat_r[`DFEH_STAT_FEP_VALID] <= 1'b0;
         end
         sec_stat_r[`DFEH_SECST_MDPE] <= (perr_rsp & ((perr_ev & sec_kind == KIND_PW) |
            (perr_ev & sec_kind == KIND_NPW) | ude_ev)) |
            (sec_stat_r[`DFEH_SECST_MDPE] & ~(sel_sst & w1c[`DFEH_SECST_MDPE]));
         sec_stat_r[`DFEH_SECST_DPE] <= ude_ev |
            (sec_stat_r[`DFEH_SECST_DPE] & ~(sel_sst & w1c[`DFEH_SECST_DPE]));
         sec_unc_r[`DFEH_SEC_PERR_DET] <= perr_ev |
            (sec_unc_r[`DFEH_SEC_PERR_DET] & ~(sel_sun & w1c[`DFEH_SEC_PERR_DET]));
         sec_unc_r[`DFEH_SEC_UDE] <= ude_ev |
            (sec_unc_r[`DFEH_SEC_UDE] & ~(sel_sun & w1c[`DFEH_SEC_UDE]));
         // Secondary log and pointer; parity pin event has priority if both hit
         if ((perr_unm | ude_unm) & ~sec_fep_r[`DFEH_FEP_VALID]) begin
            sec_hdr_r <= sec_cmd_attr_addr;
            sec_fep_r <= {1'b1, 3'h0, perr_unm ? `DFEH_FEP_PERR : `DFEH_FEP_UDE};
         end else if (sel_fep & w1c[`DFEH_FEP_VALID]) begin
            sec_fep_r <= 9'h000;
         end
      end
   end

   // ******************************
   // Forwarding, messages, completions, parity pin
   // ******************************
   // Completions are issued at the end of a non-posted write or read unless a split response without a write error defers them, and on a split error message
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tlp_fwd_valid <= 1'b0;
         tlp_fwd_header <= {HDR_W{1'b0}};
         msg_fatal <= 1'b0;
         msg_nonfatal <= 1'b0;
         parity_error_pin_out <= 1'b1;
         parity_error_pin_oe <= 1'b0;
         cpl_valid <= 1'b0;
         cpl_status <= `DFEH_CPL_SC;
         cpl_poisoned <= 1'b0;
         rd_err_r <= 1'b0;
      end else begin
         tlp_fwd_valid <= tlp_valid & ~tlp_ecrc_bad;
         if (tlp_valid) begin
            tlp_fwd_header <= tlp_header;
         end
         msg_fatal <= fat_unm & fat_en;
         msg_nonfatal <= nf_unm & nf_en;
         // The bridge owns the pin only while it is the reader
         parity_error_pin_oe <= ude_ev & perr_rsp;
         parity_error_pin_out <= ~(ude_ev & perr_rsp);
         cpl_valid <= 1'b0;
         if (sec_active & perr_ev & sec_kind == KIND_NPW) begin
            rd_err_r <= 1'b1;
         end
         if (ude_ev) begin
            rd_err_r <= 1'b1;
         end
         if (sec_split_err_msg) begin
            cpl_valid <= 1'b1;
            cpl_status <= `DFEH_CPL_UR;
            cpl_poisoned <= 1'b0;
         end else if (sec_active & sec_end & sec_kind == KIND_NPW) begin
            // Split response without an error: normal end, no completion now
            cpl_valid <= ~sec_split_resp | rd_err_r | perr_ev;
            cpl_status <= (rd_err_r | perr_ev) ? `DFEH_CPL_UR : `DFEH_CPL_SC;
            cpl_poisoned <= 1'b0;
            rd_err_r <= 1'b0;
         end else if (sec_active & sec_end & sec_kind == KIND_RD) begin
            cpl_valid <= ~sec_split_resp;
            cpl_status <= `DFEH_CPL_SC;
            cpl_poisoned <= rd_err_r | ude_ev;
            rd_err_r <= 1'b0;
         end else if (sec_active & sec_end) begin
            rd_err_r <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// ==== pkg/dfeh_consts.vh ====
`ifndef DFEH_CONSTS_VH
`define DFEH_CONSTS_VH
// ******************************
// Register byte offsets
// ******************************
`define DFEH_OFF_CTRL 12'h000
`define DFEH_OFF_STAT 12'h004
`define DFEH_OFF_UNC_STAT 12'h008
`define DFEH_OFF_UNC_MASK 12'h00C
`define DFEH_OFF_UNC_SEV 12'h010
`define DFEH_OFF_HDR_LOG 12'h014
`define DFEH_OFF_SEC_STAT 12'h018
`define DFEH_OFF_SEC_UNC_STAT 12'h01C
`define DFEH_OFF_SEC_MASK 12'h020
`define DFEH_OFF_SEC_SEV 12'h024
`define DFEH_OFF_SEC_HDR_LOG 12'h028
`define DFEH_OFF_SEC_FEP 12'hFEC
// ******************************
// Control register fields
// ******************************
`define DFEH_CTRL_SERR_EN 0
`define DFEH_CTRL_NF_EN 1
`define DFEH_CTRL_FAT_EN 2
`define DFEH_CTRL_SEC_PERR_RSP 3
// ******************************
// Status register fields (write one to clear)
// ******************************
`define DFEH_STAT_DET_PERR 0
`define DFEH_STAT_SIG_SERR 1
`define DFEH_STAT_NF_DET 2
`define DFEH_STAT_FAT_DET 3
`define DFEH_STAT_FEP_VALID 4
// ******************************
// Uncorrectable, secondary status and first error pointer bit positions and codes
// ******************************
`define DFEH_UNC_ECRC 0
`define DFEH_SEC_PERR_DET 0
`define DFEH_SEC_UDE 1
`define DFEH_SECST_MDPE 0
`define DFEH_SECST_DPE 1
`define DFEH_FEP_VALID 8
`define DFEH_FEP_PERR 5'h00
`define DFEH_FEP_UDE 5'h01
// ******************************
// Reset values and completion codes
// ******************************
`define DFEH_RST_ZERO 32'h00000000
`define DFEH_CPL_SC 3'h0
`define DFEH_CPL_UR 3'h1
`endif

// ==== bench/dfeh_assertions.sv ====
`timescale 1ns/100ps
`default_nettype none
module dfeh_assertions (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic tlp_valid,
   input wire logic tlp_ecrc_bad,
   input wire logic tlp_fwd_valid,
   input wire logic sec_active,
   input wire logic [1:0] sec_kind,
   input wire logic sec_end,
   input wire logic sec_split_resp,
   input wire logic sec_split_err_msg,
   input wire logic sec_read_data_err,
   input wire logic sec_continue,
   input wire logic parity_error_pin_in,
   input wire logic parity_error_pin_oe,
   input wire logic cpl_valid,
   input wire logic [2:0] cpl_status,
   input wire logic msg_fatal,
   input wire logic msg_nonfatal
);
   // Event causes, named so the checks below stay readable
   wire ecrc_ev = tlp_valid && tlp_ecrc_bad;
   wire rd_end = sec_end && sec_kind == 2'h2 && !sec_split_resp;
   wire cpl_ev = sec_end && (sec_kind == 2'h1 || sec_kind == 2'h2) || sec_split_err_msg;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_ecrc_drop: assert property (ecrc_ev |=> !tlp_fwd_valid) else $error("Corrupt TLP forwarded");
   a_good_fwd: assert property (tlp_valid && !tlp_ecrc_bad |=> tlp_fwd_valid) else $error("Good TLP lost");
   a_flow_on: assert property (sec_active |-> sec_continue) else $error("Transfer cut short");
   a_pin_cause: assert property ($rose(parity_error_pin_oe) |-> $past(sec_read_data_err))
      else $error("Pin driven without read error");
   a_read_ok: assert property (rd_end |=> cpl_valid && cpl_status == 3'h0) else $error("Read not successful");
   a_cpl_cause: assert property (cpl_valid |-> $past(cpl_ev)) else $error("Completion without cause");
   a_msg_excl: assert property (!(msg_fatal && msg_nonfatal)) else $error("Both message kinds");
   // Pin events take three or four edges through the synchroniser
   a_msg_cause: assert property (msg_fatal || msg_nonfatal |-> $past(ecrc_ev) || $past(sec_read_data_err)
      || !$past(parity_error_pin_in, 3) || !$past(parity_error_pin_in, 4)) else $error("Message without cause");
endmodule
bind dfeh_top dfeh_assertions u_chk (.*);
`default_nettype wire

// ==== bench/dfeh_sec_target.sv ====
`timescale 1ns/100ps
`default_nettype none
module dfeh_sec_target (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic wr_phase,
   input wire logic bad_par,
   output logic perr_n
);
   logic [1:0] dly_r;
   // Bad write parity is reported two clocks after its data phase
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) dly_r <= 2'h0;
      else dly_r <= {dly_r[0], wr_phase && bad_par};
   end
   // Pulled up, so a released pin reads high
   assign perr_n = !dly_r[1];
endmodule
`default_nettype wire

// ==== bench/test_downstream_forwarding_error_handler.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "dfeh_consts.vh"
module test_downstream_forwarding_error_handler;
   logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, sec_poisoned = 1'h0;
   logic tlp_valid = 1'h0, tlp_ecrc_bad = 1'h0, sec_active = 1'h0, sec_end = 1'h0, sec_split_resp = 1'h0;
   logic sec_split_err_msg = 1'h0, sec_read_data_err = 1'h0, bad_par = 1'h0, erb, pd, e, b, sp;
   logic [1:0] sec_kind = 2'h0, ms, xm, k;
   logic [4:0] cp, xc;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = '0, tlp_header = '0, sec_cmd_attr_addr = '0, rd, ctl, um, us, sm, ss;
   logic [31:0] st, ust, sst, sust, fep, hl, shl, h, a;
   wire [31:0] prdata, tlp_fwd_header;
   wire [2:0] cpl_status;
   wire pready, pslverr, tlp_fwd_valid, parity_error_pin_out, parity_error_pin_oe, sec_continue, cpl_valid;
   wire cpl_poisoned, msg_fatal, msg_nonfatal, tgt_n;
   wire wr_ph = sec_active && sec_kind != 2'h2;
   // Open-drain pin: low while either side pulls it
   wire parity_error_pin_in = parity_error_pin_oe && !parity_error_pin_out ? 1'h0 : tgt_n;
   int errors = 0, comparisons = 0, i;
   dfeh_top dut (.*);
   dfeh_sec_target tgt (.pclk(pclk), .presetn(presetn), .wr_phase(wr_ph), .bad_par(bad_par), .perr_n(tgt_n));
   always #2.5 pclk = ~pclk;
   // Pulses last one cycle, so gather them at every falling edge
   always @(negedge pclk) begin
      ms = ms | {msg_fatal, msg_nonfatal};
      if (cpl_valid) cp = {1'h1, cpl_status, cpl_poisoned};
      pd = pd | (parity_error_pin_oe && !parity_error_pin_out);
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      comparisons++;
      if (g !== x) begin
         errors++;
         $display("Error %0t: got %h, expected %h", $time, g, x);
      end
   endtask
   // One APB transfer; data is taken at the rising edge that sees pready high
   task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
      @(posedge pclk);
      {psel, pwrite, paddr, pwdata} <= {1'h1, w, ad, d};
      @(posedge pclk);
      penable <= 1'h1;
      do @(posedge pclk); while (pready !== 1'h1);
      rd = prdata;
      erb = pslverr;
      {psel, penable} <= 2'h0;
   endtask
   task automatic rc(input logic [11:0] ad, input logic [31:0] x);
      apb(1'h0, ad, '0);
      chk(rd, x);
   endtask
   task automatic cfg();
      ctl = $urandom % 8 + (i & 4) * 2;
      {um, us, sm, ss} = {$urandom % 2, $urandom % 2, $urandom % 4, $urandom % 4};
      apb(1'h1, `DFEH_OFF_CTRL, ctl);
      apb(1'h1, `DFEH_OFF_UNC_MASK, um);
      apb(1'h1, `DFEH_OFF_UNC_SEV, us);
      apb(1'h1, `DFEH_OFF_SEC_MASK, sm);
      apb(1'h1, `DFEH_OFF_SEC_SEV, ss);
      {ms, cp, pd, xm} = '0;
   endtask
   task automatic clr();
      apb(1'h1, `DFEH_OFF_STAT, 32'hFFFFFFFF);
      apb(1'h1, `DFEH_OFF_UNC_STAT, 32'hFFFFFFFF);
      apb(1'h1, `DFEH_OFF_SEC_STAT, 32'hFFFFFFFF);
      apb(1'h1, `DFEH_OFF_SEC_UNC_STAT, 32'hFFFFFFFF);
      apb(1'h1, `DFEH_OFF_SEC_FEP, 32'h00000100);
      {st, ust, sst, sust, fep} = '0;
   endtask
   // Model of status bits and message choice shared by every error
   task automatic note(input logic m, input logic s);
      st = st | (s ? 32'h8 : 32'h4);
      st[1] = st[1] | (!m && ctl[0]);
      xm = (m || !(ctl[0] || ctl[s ? 2 : 1])) ? 2'h0 : {s, !s};
   endtask
   task automatic tlp(input logic bad, input logic [31:0] hd);
      @(posedge pclk);
      {tlp_valid, tlp_ecrc_bad, tlp_header} <= {1'h1, bad, hd};
      @(posedge pclk);
      tlp_valid <= 1'h0;
      @(negedge pclk);
      chk(tlp_fwd_valid, !bad);
      if (!bad) chk(tlp_fwd_header, hd);
   endtask
   // Ending waits past the pin synchroniser so a late error still shapes the completion
   task automatic sx(input logic [31:0] ad);
      @(posedge pclk);
      {sec_active, sec_kind, sec_cmd_attr_addr, bad_par, sec_read_data_err} <= {1'h1, k, ad, e && !b, e && b};
      @(posedge pclk);
      {bad_par, sec_read_data_err} <= 2'h0;
      repeat (6) begin
         @(negedge pclk);
         chk(sec_continue, 1'h1);
      end
      @(posedge pclk);
      {sec_end, sec_split_resp} <= {1'h1, sp};
      @(posedge pclk);
      {sec_active, sec_end, sec_split_resp} <= 3'h0;
      repeat (5) @(posedge pclk);
   endtask
   task automatic close_out();
      if (errors == 0 && comparisons > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // Hang guard, well beyond the normal run
   initial begin
      #150000;
      errors++;
      close_out();
   end
   initial begin
      void'($urandom(32'h0444F485));
      {ms, cp, pd, st, ust, sst, sust, fep, hl, shl} = '0;
      repeat (5) @(posedge pclk);
      presetn <= 1'h1;
      rc(`DFEH_OFF_STAT, st);
      rc(`DFEH_OFF_SEC_FEP, fep);
      apb(1'h0, 12'h100, '0);
      chk(erb, 1'h1);
      for (i = 0; i < 6; i++) begin
         cfg();
         h = $urandom;
         tlp(1'h1, h);
         note(um[0], us[0]);
         st[0] = 1'h1;
         ust = 32'h1;
         if (!um[0] && !st[4]) begin
            hl = h;
            st[4] = 1'h1;
         end
         @(negedge pclk);
         chk(ms, xm);
         rc(`DFEH_OFF_STAT, st);
         rc(`DFEH_OFF_UNC_STAT, ust);
         rc(`DFEH_OFF_HDR_LOG, hl);
         tlp(1'h0, $urandom);
         if (i % 3 == 2) clr();
      end
      for (i = 0; i < 16; i++) begin
         cfg();
         k = i % 4;
         b = k == 2'h2;
         a = $urandom;
         e = i < 8 || $urandom % 2;
         sp = (k == 2'h1 || b && !e) && $urandom % 2;
         sx(a);
         if (e) begin
            note(sm[b], ss[b]);
            sust[b] = 1'h1;
            sst[1] = sst[1] | b;
            sst[0] = sst[0] | (ctl[3] && k < 2'h3);
            if (!sm[b] && !fep[8]) begin
               fep = {23'h0, 1'h1, 7'h0, b};
               shl = a;
            end
         end
         xc = k == 2'h1 ? (e ? 5'h12 : sp ? 5'h00 : 5'h10) : b && !sp ? {4'h8, e} : 5'h00;
         chk(ms, xm);
         chk(cp, xc);
         chk(pd, e && b && ctl[3]);
         rc(`DFEH_OFF_SEC_STAT, sst);
         rc(`DFEH_OFF_SEC_UNC_STAT, sust);
         rc(`DFEH_OFF_SEC_FEP, fep);
         rc(`DFEH_OFF_SEC_HDR_LOG, shl);
         rc(`DFEH_OFF_STAT, st);
         if (i % 4 == 3) clr();
      end
      cp = '0;
      @(posedge pclk);
      sec_split_err_msg <= 1'h1;
      @(posedge pclk);
      sec_split_err_msg <= 1'h0;
      repeat (2) @(negedge pclk);
      chk(cp, 5'h12);
      close_out();
   end
endmodule
`default_nettype wire
